// *** apm_pkg.sv ***
// apm_pkg: register map, field layout and constants of the protection monitor
// assumes: 32-bit plain register port, word addresses are byte offsets / 4
package apm_pkg;
  localparam int apm_channels = 4;
  localparam int apm_word_w = 32;
  localparam int apm_addr_w = 8;
  // register byte offsets
  localparam logic [7:0] apm_reg_control = 8'h00;
  localparam logic [7:0] apm_reg_fault_status = 8'h04;
  localparam logic [7:0] apm_reg_warn_status = 8'h08;
  localparam logic [7:0] apm_reg_fault_mask = 8'h0c;
  localparam logic [7:0] apm_reg_clip_threshold = 8'h10;
  localparam logic [7:0] apm_reg_load_thresholds = 8'h14;
  localparam logic [7:0] apm_reg_foldback = 8'h18;
  localparam logic [7:0] apm_reg_channel_state = 8'h1c;
  localparam logic [7:0] apm_reg_dc_resistance = 8'h20;
  localparam logic [7:0] apm_reg_ac_real = 8'h24;
  localparam logic [7:0] apm_reg_ac_imag = 8'h28;
  localparam logic [7:0] apm_reg_attenuation = 8'h2c;
  localparam logic [7:0] apm_reg_pump = 8'h30;
  // control register fields
  localparam int apm_ctl_dc_detect_en = 0;
  localparam int apm_ctl_clip_en = 1;
  localparam int apm_ctl_supply_aware = 2;
  localparam int apm_ctl_realtime_en = 3;
  localparam int apm_ctl_sense_en = 4;
  localparam int apm_ctl_sense_tx_en = 5;
  localparam int apm_ctl_pilot_en = 6;
  localparam logic [31:0] apm_ctl_reset = 32'h0000_0049;
  // fault status nibble lanes: overcurrent, dc, overheat, pump/global
  localparam int apm_fs_overcurrent = 0;
  localparam int apm_fs_dc = 4;
  localparam int apm_fs_overheat = 8;
  localparam int apm_fs_global_heat = 12;
  localparam int apm_fs_pump = 13;
  // warning status lanes: limit, clip, heat warn, shorted, open, global
  localparam int apm_ws_limit = 0;
  localparam int apm_ws_clip = 4;
  localparam int apm_ws_heat = 8;
  localparam int apm_ws_shorted = 12;
  localparam int apm_ws_open = 16;
  localparam int apm_ws_global_heat = 20;
  localparam logic [31:0] apm_fault_mask_reset = 32'h0000_0000;
  // fixed temperature codes, not writable
  localparam logic [7:0] apm_heat_shutdown_code = 8'h96;
  localparam logic [7:0] apm_heat_warning_code = 8'h82;
  // gain steps in units of 0.05dB
  localparam logic [7:0] apm_attack_step_reset = 8'h05;
  localparam logic [7:0] apm_release_step_reset = 8'h02;
  localparam logic [7:0] apm_hold_samples_reset = 8'h10;
  localparam logic [7:0] apm_foldback_level_reset = 8'h78;
  localparam logic [7:0] apm_max_atten_reset = 8'h78;
  localparam logic [15:0] apm_clip_threshold_reset = 16'h7c00;
  localparam logic [7:0] apm_shorted_limit_reset = 8'h04;
  localparam logic [7:0] apm_open_limit_reset = 8'h80;
  localparam logic [1:0] apm_pump_consecutive_max = 2'h2;
  localparam logic [1:0] apm_pump_total_max = 2'h3;
endpackage

// *** apm_monitor.sv ***
// apm_monitor: protection and monitoring logic of a four-channel amplifier
// assumes: analog sensors deliver codes asynchronous to clk_in; the
// sample strobe comes from the audio clock generator in the same domain
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - keep AC diagnostic real and imaginary impedance per channel after run, readable for channels 0 and 1
// - in play derive impedance from current sense, flag short/open loads
// - inject a low-level pilot so load check works without audio
// - DC resistance reads valid only after DC diagnostic finished
// - transient overcurrent clamps each cycle, channel keeps playing
// - shutdown current level raises event, faults only that channel
// - enabled fault events drive the fault pin low by default
// - sample all currents each sample, output when both setups enabled
// - continuous DC offset check faults the channel past threshold
// - per-channel clip compare at filter input raises clip warning
// - supply-aware clip mode scales by analog gain and supply
// - pump fault skips a clock, counts it, retries next clock
// - two consecutive or three total pump faults shut the pump down
// - five sensors, per-channel plus global, give warnings and faults
// - global overheat shuts all channels and records event
// - channel overheat shuts only that channel and records event
// - shutdown thresholds are fixed constants
// - warning temperature gives pollable warning events, no interruption
// - above foldback level, reduce gain each sample by attack step
// - below level hold attenuation, then release by release step
// - each level has its own maximum attenuation, no stacking
// - faulted channel keeps outputs tri-stated and processing stopped
module apm_monitor #(
  parameter int channels = 4,
  parameter int sense_w = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // sample timing and per-channel state from the channel controller
  input wire logic sample_strobe_in,
  input wire logic [3:0] channel_playing_in,
  // analog comparators and sensors (asynchronous)
  input wire logic [3:0] over_limit_in,
  input wire logic [3:0] over_shutdown_in,
  input wire logic [3:0] dc_offset_over_in,
  input wire logic pump_fault_in,
  input wire logic pump_clock_in,
  input wire logic [7:0] global_temp_in,
  input wire logic [31:0] channel_temp_in,
  // audio path data (same domain)
  input wire logic [63:0] filter_input_in,
  input wire logic [63:0] current_sense_in,
  input wire logic [63:0] output_voltage_in,
  input wire logic [7:0] supply_voltage_in,
  input wire logic [7:0] analog_gain_in,
  // diagnostic results
  input wire logic dc_diag_done_in,
  input wire logic [3:0] dc_diag_channel_in,
  input wire logic [7:0] dc_resistance_in,
  input wire logic ac_diag_done_in,
  input wire logic [1:0] ac_diag_channel_in,
  input wire logic [15:0] ac_real_in,
  input wire logic [15:0] ac_imag_in,
  // outputs
  output logic [3:0] clamp_cycle_out,
  output logic [3:0] channel_fault_out,
  output logic [3:0] output_hiz_out,
  output logic [3:0] processing_stop_out,
  output logic pump_enable_out,
  output logic pump_clock_out,
  output logic fault_pin_out,
  output logic fault_pin_oe_n_out,
  output logic warning_out,
  output logic pilot_enable_out,
  output logic [63:0] sense_tx_data_out,
  output logic sense_tx_valid_out,
  output logic [31:0] attenuation_out
);

////////////////////////////////////////////////////////////////////////////
// synchronisers for asynchronous inputs
  logic [3:0] lim_s1, lim_s2, sd_s1, sd_s2, dco_s1, dco_s2;
  logic pf_s1, pf_s2, pc_s1, pc_s2, pc_d;
  logic [7:0] gt_s1, gt_s2;
  logic [31:0] ct_s1, ct_s2;

  always_ff @(posedge clk_in) begin
    lim_s1 <= over_limit_in;
    lim_s2 <= lim_s1;
    sd_s1 <= over_shutdown_in;
    sd_s2 <= sd_s1;
    dco_s1 <= dc_offset_over_in;
    dco_s2 <= dco_s1;
    pf_s1 <= pump_fault_in;
    pf_s2 <= pf_s1;
    pc_s1 <= pump_clock_in;
    pc_s2 <= pc_s1;
    pc_d <= pc_s2;
    gt_s1 <= global_temp_in;
    gt_s2 <= gt_s1;
    ct_s1 <= channel_temp_in;
    ct_s2 <= ct_s1;
  end

////////////////////////////////////////////////////////////////////////////
// registers
  logic [31:0] control, fault_status, warn_status, fault_mask;
  logic [15:0] clip_threshold;
  logic [7:0] shorted_limit, open_limit;
  logic [7:0] foldback_level, max_atten, attack_step, release_step;
  logic [7:0] hold_samples;
  logic [3:0] channel_fault, dc_valid;
  logic [7:0] dc_res [4];
  logic [15:0] ac_real [4];
  logic [15:0] ac_imag [4];
  logic [7:0] atten [4];
  logic [7:0] hold_count [4];
  logic [1:0] pump_consec, pump_total;
  logic pump_dead;

  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  wire wr_control = reg_write_in && reg_addr_in == apm_pkg::apm_reg_control;
  wire wr_fault = reg_write_in && reg_addr_in == apm_pkg::apm_reg_fault_status;
  wire wr_warn = reg_write_in && reg_addr_in == apm_pkg::apm_reg_warn_status;
  wire wr_mask = reg_write_in && reg_addr_in == apm_pkg::apm_reg_fault_mask;
  wire wr_clip = reg_write_in
    && reg_addr_in == apm_pkg::apm_reg_clip_threshold;
  wire wr_load = reg_write_in
    && reg_addr_in == apm_pkg::apm_reg_load_thresholds;
  wire wr_fold = reg_write_in && reg_addr_in == apm_pkg::apm_reg_foldback;
  wire wr_state = reg_write_in
    && reg_addr_in == apm_pkg::apm_reg_channel_state;
  wire wr_pump = reg_write_in && reg_addr_in == apm_pkg::apm_reg_pump;

////////////////////////////////////////////////////////////////////////////
// event detection
  logic [3:0] clip_hit, shorted_hit, open_hit, heat_sd, heat_warn, fold_hot;
  wire global_sd = gt_s2 > apm_pkg::apm_heat_shutdown_code;
  wire global_warn = gt_s2 > apm_pkg::apm_heat_warning_code;
  wire pump_edge = pc_s2 && !pc_d;
  wire pump_fault_now = pump_edge && pf_s2 && !pump_dead;

  always_comb begin
    logic [15:0] mag, cur, volt;
    logic [23:0] scaled;
    mag = 16'h0;
    cur = 16'h0;
    volt = 16'h0;
    scaled = 24'h0;
    for (int i = 0; i < 4; i++) begin
      mag = mag16(filter_input_in[16*i +: 16]);
      // supply-aware: gain over supply
      scaled = {8'h0, mag} * {16'h0, analog_gain_in} / 24'({supply_voltage_in, 8'h1});
      clip_hit[i] = control[apm_pkg::apm_ctl_clip_en]
        && (control[apm_pkg::apm_ctl_supply_aware]
        ? scaled[15:0] > clip_threshold
        : mag > clip_threshold);
      cur = mag16(current_sense_in[16*i +: 16]);
      volt = mag16(output_voltage_in[16*i +: 16]);
      // impedance ratio via cross-multiplied compare against limits
      shorted_hit[i] = channel_playing_in[i]
        && control[apm_pkg::apm_ctl_realtime_en] && cur != 16'h0
        && {8'h0, volt} < 24'({8'h0, cur} * {16'h0, shorted_limit});
      open_hit[i] = channel_playing_in[i]
        && control[apm_pkg::apm_ctl_realtime_en]
        && {8'h0, volt} > 24'({8'h0, cur} * {16'h0, open_limit});
      heat_sd[i] = ct_s2[8*i +: 8] > apm_pkg::apm_heat_shutdown_code;
      heat_warn[i] = ct_s2[8*i +: 8] > apm_pkg::apm_heat_warning_code;
      fold_hot[i] = ct_s2[8*i +: 8] > foldback_level;
    end
  end

  wire [3:0] dc_hit = dco_s2 & {4{control[apm_pkg::apm_ctl_dc_detect_en]}};
  wire [3:0] new_fault = sd_s2 | dc_hit | heat_sd | {4{global_sd}}
    | {4{pump_dead}};
  wire [31:0] fault_events = {18'h0, pump_dead, global_sd, heat_sd,
    dc_hit, sd_s2};
  wire [31:0] warn_events = {11'h0, global_warn, open_hit, shorted_hit,
    heat_warn, clip_hit, lim_s2};

////////////////////////////////////////////////////////////////////////////
// status, configuration and channel fault latches
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      control <= apm_pkg::apm_ctl_reset;
      fault_status <= 32'h0;
      warn_status <= 32'h0;
      fault_mask <= apm_pkg::apm_fault_mask_reset;
      clip_threshold <= apm_pkg::apm_clip_threshold_reset;
      shorted_limit <= apm_pkg::apm_shorted_limit_reset;
      open_limit <= apm_pkg::apm_open_limit_reset;
      foldback_level <= apm_pkg::apm_foldback_level_reset;
      max_atten <= apm_pkg::apm_max_atten_reset;
      attack_step <= apm_pkg::apm_attack_step_reset;
      release_step <= apm_pkg::apm_release_step_reset;
      hold_samples <= apm_pkg::apm_hold_samples_reset;
      channel_fault <= 4'h0;
    end else begin
      if (wr_control) control <= reg_wdata_in;
      if (wr_mask) fault_mask <= reg_wdata_in;
      if (wr_clip) clip_threshold <= reg_wdata_in[15:0];
      if (wr_load) begin
        shorted_limit <= reg_wdata_in[7:0];
        open_limit <= reg_wdata_in[15:8];
      end
      if (wr_fold) begin
        foldback_level <= reg_wdata_in[7:0];
        max_atten <= reg_wdata_in[15:8];
        attack_step <= reg_wdata_in[23:16];
        release_step <= reg_wdata_in[31:24];
      end
      if (wr_pump) hold_samples <= reg_wdata_in[7:0];
      // w1c, event wins over clear
      fault_status <= (fault_status & ~(wr_fault ? reg_wdata_in : 32'h0))
        | fault_events;
      warn_status <= (warn_status & ~(wr_warn ? reg_wdata_in : 32'h0))
        | warn_events;
      // held until host release
      channel_fault <= (channel_fault & ~(wr_state ? reg_wdata_in[3:0]
        : 4'h0)) | new_fault;
    end
  end

////////////////////////////////////////////////////////////////////////////
// charge pump fault counting
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pump_consec <= 2'h0;
      pump_total <= 2'h0;
      pump_dead <= 1'b0;
    end else if (wr_pump && reg_wdata_in[8]) begin
      pump_consec <= 2'h0;
      pump_total <= 2'h0;
      pump_dead <= 1'b0;
    end else if (pump_edge && !pump_dead) begin
      if (pf_s2) begin
        pump_consec <= pump_consec + 2'h1;
        pump_total <= pump_total + 2'h1;
        if (pump_consec + 2'h1 == apm_pkg::apm_pump_consecutive_max
            || pump_total + 2'h1 == apm_pkg::apm_pump_total_max)
          pump_dead <= 1'b1;
      end else begin
        pump_consec <= 2'h0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
// diagnostic result storage and thermal foldback
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dc_valid <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        dc_res[i] <= 8'h0;
        ac_real[i] <= 16'h0;
        ac_imag[i] <= 16'h0;
        atten[i] <= 8'h0;
        hold_count[i] <= 8'h0;
      end
    end else begin
      if (dc_diag_done_in) begin
        dc_valid <= dc_valid | dc_diag_channel_in;
        for (int i = 0; i < 4; i++)
          if (dc_diag_channel_in[i]) dc_res[i] <= dc_resistance_in;
      end
      if (ac_diag_done_in) begin
        ac_real[ac_diag_channel_in] <= ac_real_in;
        ac_imag[ac_diag_channel_in] <= ac_imag_in;
      end
      if (sample_strobe_in) begin
        for (int i = 0; i < 4; i++) begin
          if (fold_hot[i]) begin
            hold_count[i] <= hold_samples;
            // capped at level limit
            atten[i] <= (9'(atten[i]) + 9'(attack_step) > 9'(max_atten))
              ? max_atten : 8'(atten[i] + attack_step);
          end else if (hold_count[i] != 8'h0) begin
            hold_count[i] <= hold_count[i] - 8'h1;
          end else begin
            atten[i] <= (atten[i] > release_step)
              ? 8'(atten[i] - release_step) : 8'h0;
          end
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
// read port
  logic [31:0] next_rdata;
  always_comb begin
    case (reg_addr_in)
      apm_pkg::apm_reg_control: next_rdata = control;
      apm_pkg::apm_reg_fault_status: next_rdata = fault_status;
      apm_pkg::apm_reg_warn_status: next_rdata = warn_status;
      apm_pkg::apm_reg_fault_mask: next_rdata = fault_mask;
      apm_pkg::apm_reg_clip_threshold: next_rdata = {16'h0, clip_threshold};
      apm_pkg::apm_reg_load_thresholds:
        next_rdata = {16'h0, open_limit, shorted_limit};
      apm_pkg::apm_reg_foldback:
        next_rdata = {release_step, attack_step, max_atten, foldback_level};
      apm_pkg::apm_reg_channel_state:
        next_rdata = {24'h0, dc_valid, channel_fault};
      // zero until diagnostic done
      apm_pkg::apm_reg_dc_resistance:
        next_rdata = {dc_valid[3] ? dc_res[3] : 8'h0,
          dc_valid[2] ? dc_res[2] : 8'h0,
          dc_valid[1] ? dc_res[1] : 8'h0,
          dc_valid[0] ? dc_res[0] : 8'h0};
      apm_pkg::apm_reg_ac_real: next_rdata = {ac_real[1], ac_real[0]};
      apm_pkg::apm_reg_ac_imag: next_rdata = {ac_imag[1], ac_imag[0]};
      apm_pkg::apm_reg_attenuation:
        next_rdata = {atten[3], atten[2], atten[1], atten[0]};
      apm_pkg::apm_reg_pump:
        next_rdata = {19'h0, pump_dead, pump_total, pump_consec,
          hold_samples};
      default: next_rdata = 32'h0;
    endcase
  end

////////////////////////////////////////////////////////////////////////////
// registered outputs
  wire fault_active = |(fault_status & ~fault_mask);
  wire sense_on = control[apm_pkg::apm_ctl_sense_en]
    && control[apm_pkg::apm_ctl_sense_tx_en];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 32'h0;
      clamp_cycle_out <= 4'h0;
      channel_fault_out <= 4'h0;
      output_hiz_out <= 4'hf;
      processing_stop_out <= 4'hf;
      pump_enable_out <= 1'b0;
      pump_clock_out <= 1'b0;
      fault_pin_out <= 1'b0;
      fault_pin_oe_n_out <= 1'b1;
      warning_out <= 1'b0;
      pilot_enable_out <= 1'b0;
      sense_tx_data_out <= 64'h0;
      sense_tx_valid_out <= 1'b0;
      attenuation_out <= 32'h0;
    end else begin
      reg_rdata_out <= reg_read_in ? next_rdata : 32'h0;
      clamp_cycle_out <= lim_s2 & ~channel_fault;
      channel_fault_out <= channel_fault;
      output_hiz_out <= channel_fault | ~channel_playing_in;
      processing_stop_out <= channel_fault;
      pump_enable_out <= !pump_dead;
      pump_clock_out <= pc_s2 && !pf_s2 && !pump_dead;
      fault_pin_out <= 1'b0;
      fault_pin_oe_n_out <= !fault_active;
      warning_out <= |warn_status;
      pilot_enable_out <= control[apm_pkg::apm_ctl_pilot_en]
        && control[apm_pkg::apm_ctl_realtime_en]
        && |channel_playing_in;
      sense_tx_valid_out <= sense_on && sample_strobe_in;
      if (sense_on && sample_strobe_in)
        sense_tx_data_out <= current_sense_in;
      attenuation_out <= {atten[3], atten[2], atten[1], atten[0]};
    end
  end
endmodule

// *** apm_assertions.sv ***
// apm_monitor_assertions: port-level temporal checks of the monitor
// assumes: one clock domain, synchronous active-high reset
`timescale 1ns/10ps
module apm_monitor_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // causes
  input wire logic [3:0] channel_playing_in,
  input wire logic [3:0] over_limit_in,
  input wire logic [3:0] over_shutdown_in,
  input wire logic [7:0] global_temp_in,
  // effects
  input wire logic [3:0] clamp_cycle_out,
  input wire logic [3:0] channel_fault_out,
  input wire logic [3:0] output_hiz_out,
  input wire logic [3:0] processing_stop_out,
  input wire logic pump_enable_out,
  input wire logic pump_clock_out,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe_n_out,
  input wire logic sense_tx_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  sequence shutdown_held;
    ($stable(over_shutdown_in) && over_shutdown_in != 4'h0)[*6];
  endsequence
  sequence limit_held;
    $stable(over_limit_in & channel_playing_in)[*5];
  endsequence
  sequence die_hot;
    (global_temp_in > apm_pkg::apm_heat_shutdown_code)[*6];
  endsequence
  sequence any_fault;
    (channel_fault_out != 4'h0)[*2];
  endsequence
  ////////////////////////////////////////
  fault_hiz_a:
    assert property ((channel_fault_out & ~output_hiz_out) == 4'h0)
    else $error("fault drives output");
  fault_stop_a:
    assert property ((channel_fault_out & ~processing_stop_out) == 4'h0)
    else $error("fault keeps processing");
  shutdown_fault_a:
    assert property (shutdown_held |->
      (channel_fault_out & over_shutdown_in) == over_shutdown_in)
    else $error("shutdown not faulted");
  limit_clamp_a:
    assert property (limit_held |-> (clamp_cycle_out & channel_playing_in)
      == (over_limit_in & channel_playing_in))
    else $error("clamp mismatch");
  global_heat_a:
    assert property (die_hot |-> channel_fault_out == 4'hf)
    else $error("hot die not shut");
  pin_low_a:
    assert property (any_fault |-> !fault_pin_oe_n_out && !fault_pin_out)
    else $error("fault pin not pulled low");
  pump_quiet_a:
    assert property (!pump_enable_out [*2] |-> !pump_clock_out)
    else $error("dead pump still clocked");
  tx_pulse_a:
    assert property (sense_tx_valid_out |=> !sense_tx_valid_out)
    else $error("sense valid too long");
endmodule
bind apm_monitor apm_monitor_assertions apm_monitor_assertions_i (.*);

// *** apm_load_model.sv ***
// apm_load_model: speaker loads and charge pump seen from the monitor
// assumes: bench selects open or shorted loads and a faulty pump
`timescale 1ns/10ps
module apm_load_model (
  // clock
  input wire logic clk_in,
  // conditions chosen by the bench
  input wire logic [3:0] open_in,
  input wire logic [3:0] short_in,
  input wire logic pump_bad_in,
  // sensed values
  output logic [63:0] current_sense_out,
  output logic [63:0] output_voltage_out,
  output logic pump_clock_out,
  output logic pump_fault_out
);
  logic [2:0] div = 3'h0;
  always_ff @(posedge clk_in) begin
    div <= div + 3'h1;
  end
  assign pump_clock_out = div[2];
  assign pump_fault_out = pump_bad_in;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      current_sense_out[16*k +: 16] = open_in[k] ? 16'h0000 :
        (short_in[k] ? 16'h4000 : 16'h0400);
      output_voltage_out[16*k +: 16] = short_in[k] ? 16'h0000 : 16'h2000;
    end
  end
endmodule

// *** apm_monitor_bench.sv ***
// apm_monitor_bench: self-checking bench of the protection monitor
// assumes: 200 MHz clock, register port answers one cycle after a read
`timescale 1ns/10ps
module apm_monitor_bench;
  logic clk_in = 1'b0, reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, attenuation_out;
  logic reg_write_in = 1'b0, reg_read_in = 1'b0, sample_strobe_in = 1'b0;
  logic dc_diag_done_in = 1'b0, ac_diag_done_in = 1'b0, pump_bad = 1'b0;
  logic [3:0] channel_playing_in = 4'hf, over_limit_in = 4'h0;
  logic [3:0] over_shutdown_in = 4'h0, dc_offset_over_in = 4'h0;
  logic [3:0] open_load = 4'h0, short_load = 4'h0, dc_diag_channel_in = 4'h0;
  logic [7:0] global_temp_in = 8'h00, dc_resistance_in = 8'h00;
  logic [31:0] channel_temp_in = 32'h0;
  logic [1:0] ac_diag_channel_in = 2'h0;
  logic [15:0] ac_real_in = 16'h0, ac_imag_in = 16'h0;
  logic [63:0] current_sense_in, output_voltage_in, sense_tx_data_out;
  logic pump_fault_in, pump_clock_in, pump_enable_out, pump_clock_out;
  logic fault_pin_out, fault_pin_oe_n_out, warning_out, pilot_enable_out;
  logic sense_tx_valid_out;
  logic [3:0] clamp_cycle_out, channel_fault_out, output_hiz_out;
  logic [3:0] processing_stop_out;
  logic [63:0] filter_input_in = 64'h0;
  logic [7:0] supply_voltage_in = 8'h80, analog_gain_in = 8'h10;
  int failures = 0, num_checks = 0;
  apm_monitor apm_monitor_i (.*);
  apm_load_model apm_load_model_i (
    .clk_in, .open_in(open_load), .short_in(short_load),
    .pump_bad_in(pump_bad), .current_sense_out(current_sense_in),
    .output_voltage_out(output_voltage_in),
    .pump_clock_out(pump_clock_in), .pump_fault_out(pump_fault_in));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in) reg_write_in <= 1'b0;
    #1;
  endtask
  task automatic rdck(input string what, input logic [7:0] a,
    input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in) reg_read_in <= 1'b0;
    #1 check(what, exp, reg_rdata_out & mask);
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge clk_in) sample_strobe_in <= 1'b1;
      @(posedge clk_in) sample_strobe_in <= 1'b0;
      tick(5);
    end
  endtask
  task automatic clear_all();
    wr(8'h1c, 32'hf);
    wr(8'h04, '1);
    wr(8'h08, '1);
    tick(2);
    check("released", 4'h0, channel_fault_out);
  endtask
  task automatic pump_glitch(input int edges);
    @(negedge pump_clock_in);
    @(posedge clk_in) pump_bad <= 1'b1;
    repeat (8 * edges) @(posedge clk_in);
    pump_bad <= 1'b0;
    tick(8);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rdck("control", 8'h00, '1, apm_pkg::apm_ctl_reset);
    wr(8'h3c, '1);
    rdck("unmapped", 8'h3c, '1, 32'h0);
    check("pilot", 1'b1, pilot_enable_out);
    check("pin idle", 1'b1, fault_pin_oe_n_out);
  endtask
  task automatic t_limit();
    wr(8'h00, 32'h4b);
    @(posedge clk_in) over_limit_in <= 4'h2;
    filter_input_in <= 64'h8000_0000;
    tick(8);
    check("clamp", 4'h2, clamp_cycle_out);
    check("limit fault", 4'h0, channel_fault_out);
    @(posedge clk_in) over_limit_in <= 4'h0;
    filter_input_in <= 64'h0;
    tick(6);
    rdck("limit clip", 8'h08, 32'hff, 32'h22);
    wr(8'h08, 32'h22);
    rdck("limit clear", 8'h08, 32'hff, 32'h0);
  endtask
  task automatic t_trip(input int kind, input logic [31:0] exp_fs);
    @(posedge clk_in);
    if (kind == 0) over_shutdown_in <= 4'h4;
    if (kind == 1) dc_offset_over_in <= 4'h8;
    if (kind == 2) channel_temp_in <= 32'h88;
    if (kind == 3) channel_temp_in <= 32'ha0;
    if (kind == 4) global_temp_in <= 8'ha0;
    tick(8);
    rdck("fault flags", 8'h04, '1, exp_fs);
    @(posedge clk_in);
    over_shutdown_in <= 4'h0;
    dc_offset_over_in <= 4'h0;
    channel_temp_in <= 32'h0;
    global_temp_in <= 8'h00;
    tick(6);
    check("fault held", exp_fs[3:0] | exp_fs[7:4] | exp_fs[11:8] |
      {4{exp_fs[12]}}, channel_fault_out);
    if (kind == 2) rdck("heat warn", 8'h08, 32'h100, 32'h100);
    clear_all();
  endtask
  task automatic t_pump();
    pump_glitch(1);
    rdck("pump count", 8'h30, 32'h1f00, 32'h0400);
    check("pump alive", 1'b1, pump_enable_out);
    pump_glitch(1);
    pump_glitch(1);
    check("pump dead", 1'b0, pump_enable_out);
    check("pump hiz", 4'hf, output_hiz_out);
    rdck("pump flag", 8'h04, 32'h2000, 32'h2000);
    wr(8'h30, 32'h110);
    pump_glitch(2);
    check("pump twice", 1'b0, pump_enable_out);
    wr(8'h30, 32'h110);
    clear_all();
  endtask
  task automatic t_diag();
    rdck("dc early", 8'h20, 32'hff00, 32'h0);
    @(posedge clk_in);
    dc_diag_channel_in <= 4'h2;
    dc_resistance_in <= 8'h5a;
    dc_diag_done_in <= 1'b1;
    ac_diag_channel_in <= 2'h1;
    ac_real_in <= 16'h1234;
    ac_imag_in <= 16'hedcb;
    ac_diag_done_in <= 1'b1;
    @(posedge clk_in);
    dc_diag_done_in <= 1'b0;
    ac_diag_done_in <= 1'b0;
    tick(2);
    rdck("dc value", 8'h20, 32'hff00, 32'h5a00);
    rdck("dc valid", 8'h1c, 32'hf0, 32'h20);
    rdck("ac real", 8'h24, '1, 32'h1234_0000);
    rdck("ac imag", 8'h28, '1, 32'hedcb_0000);
  endtask
  task automatic t_sense(input logic [31:0] ctl, input logic exp);
    logic seen = 1'b0;
    logic [63:0] d = 64'h0;
    wr(8'h00, ctl);
    @(posedge clk_in) sample_strobe_in <= 1'b1;
    @(posedge clk_in) sample_strobe_in <= 1'b0;
    repeat (8) begin
      #1 if (sense_tx_valid_out === 1'b1) begin
        seen = 1'b1;
        d = sense_tx_data_out;
      end
      @(posedge clk_in);
    end
    #1 check("sense valid", exp, seen);
    check("sense data", exp ? 64'h0400_0400_0400_0400 : 64'h0, d);
  endtask
  task automatic t_load();
    @(posedge clk_in);
    open_load <= 4'h8;
    short_load <= 4'h1;
    strobe(4);
    rdck("load flags", 8'h08, 32'hff000, 32'h81000);
    @(posedge clk_in);
    open_load <= 4'h0;
    short_load <= 4'h0;
    clear_all();
  endtask
  task automatic t_fold();
    @(posedge clk_in) channel_temp_in <= 32'h7a00;
    tick(6);
    strobe(4);
    check("attack", 32'h1400, attenuation_out);
    @(posedge clk_in) channel_temp_in <= 32'h0;
    tick(6);
    strobe(16);
    check("hold", 32'h1400, attenuation_out);
    strobe(1);
    check("release", 32'h1200, attenuation_out);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    tick(2);
    t_regs();
    t_limit();
    t_trip(0, 32'h4);
    t_trip(1, 32'h80);
    t_trip(2, 32'h0);
    t_trip(3, 32'h100);
    t_trip(4, 32'h1000);
    t_pump();
    t_diag();
    t_sense(apm_pkg::apm_ctl_reset, 1'b0);
    t_sense(32'h79, 1'b1);
    t_load();
    t_fold();
    summarize();
  end
  initial begin
    #40us;
    failures++;
    summarize();
  end
endmodule
